// >>> dv/pin_peer.sv
// model of the peripherals wired to the multiplexed pins
// assumes one clk; an undriven line toggles so a stale level never passes
`timescale 1ns/1ps
`default_nettype none
module pin_peer
(
  // clock
  input wire logic clk,
  // bench commands
  input wire logic [15:0] peer_en,
  input wire logic [15:0] peer_drv,
  // port side
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  output logic [15:0] pin_in
);
  logic float_r = 1'h0;
  always_ff @(posedge clk)
    float_r <= ~float_r;
  // the port's drive wins wherever it enables a pin
  always_comb
    for (int i = 0; i < 16; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : (peer_en[i] ? peer_drv[i] : float_r);
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the parallel pin port
// assumes avalon-mm slave answers with one low waitrequest cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] pin_in, pin_out, pin_oe;
  logic irq;
  logic [15:0] peer_en = 16'hFFFF;
  logic [15:0] peer_drv = 16'h0000;
  logic [31:0] rd;
  int mismatches = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  parallel_pin_port u_parallel_pin_port (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq));
  pin_peer u_pin_peer (.clk(clk), .peer_en(peer_en), .peer_drv(peer_drv),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    rd = avs_readdata;
    chk("waitrequest", 32'(avs_waitrequest), 32'h00000000);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'h1, idx, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h00000000);
    chk(nm, rd, exp);
  endtask
  // pins need 3-4 cycles of sync plus a cycle for flags
  task automatic pins(input logic [15:0] en, input logic [15:0] v);
    peer_en <= en;
    peer_drv <= v;
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("way", pin_port_pkg::IDX_WAY, 32'h00000000);
    rdchk("out", pin_port_pkg::IDX_OUT, 32'h00000000);
    chk("oe", 32'(pin_oe), 32'h00000000);
    rdchk("unmapped", 8'h20, pin_port_pkg::UNMAPPED_DATA);
  endtask
  task automatic t_static;
    wr(pin_port_pkg::IDX_SETUP, 32'h00000001);
    wr(pin_port_pkg::IDX_WAY, 32'h0000FFFF);
    wr(pin_port_pkg::IDX_OUT, 32'h0000A5C3);
    pins(16'h0000, 16'h0000);
    chk("out pins", 32'(pin_out), 32'h0000A5C3);
    chk("oe all", 32'(pin_oe), 32'h0000FFFF);
    wr(pin_port_pkg::IDX_WAY, 32'h00000000);
    pins(16'hFFFF, 16'h1235);
    rdchk("in live", pin_port_pkg::IDX_IN, 32'h00001235);
  endtask
  task automatic t_edges;
    wr(pin_port_pkg::IDX_FALL, 32'h00000001);
    wr(pin_port_pkg::IDX_RISE, 32'h00000002);
    wr(pin_port_pkg::IDX_IMASK, 32'h00000001);
    wr(pin_port_pkg::IDX_STATUS, 32'h00000001);
    bus(1'h0, pin_port_pkg::IDX_HOLD, 32'h00000000);
    pins(16'hFFFF, 16'h1230);
    chk("irq fall", 32'(irq), 32'h00000001);
    rdchk("flag fall", pin_port_pkg::IDX_STATUS, 32'h00000001);
    wr(pin_port_pkg::IDX_STATUS, 32'h00000001);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'(irq), 32'h00000000);
    pins(16'hFFFF, 16'h1232);
    rdchk("flag rise", pin_port_pkg::IDX_STATUS, 32'h00000001);
    rdchk("hold sum", pin_port_pkg::IDX_HOLD, 32'h00000003);
    rdchk("hold clr", pin_port_pkg::IDX_HOLD, 32'h00000000);
    pins(16'hFFFF, 16'h1233);
    rdchk("hold masked", pin_port_pkg::IDX_HOLD, 32'h00000000);
    pins(16'hFFFF, 16'h1232);
    rdchk("hold again", pin_port_pkg::IDX_HOLD, 32'h00000001);
    wr(pin_port_pkg::IDX_FALL, 32'h00008000);
    wr(pin_port_pkg::IDX_RISE, 32'h00008000);
    wr(pin_port_pkg::IDX_WAY, 32'h00008000);
    pins(16'h7FFF, 16'h1232);
    wr(pin_port_pkg::IDX_OUT, 32'h00000000);
    pins(16'h7FFF, 16'h1232);
    rdchk("hold output", pin_port_pkg::IDX_HOLD, 32'h00000000);
  endtask
  task automatic t_slot;
    wr(pin_port_pkg::IDX_WAY, 32'h00000000);
    wr(pin_port_pkg::IDX_SETUP, 32'h00000002);
    pins(16'hFFFF, 16'h05A5);
    pins(16'hFFFF, 16'h85A5);
    // low pins move while the top pin is high, so only a capture at the fall reads A5A
    pins(16'hFFFF, 16'h8A5A);
    pins(16'hFFFF, 16'h0A5A);
    pins(16'hFFFF, 16'h0123);
    rdchk("in slot", pin_port_pkg::IDX_IN, 32'h00000A5A);
    wr(pin_port_pkg::IDX_WAY, 32'h00000FFF);
    wr(pin_port_pkg::IDX_OUT, 32'h00000ABC);
    pins(16'h8000, 16'h8000);
    chk("slot out", 32'(pin_out[11:0]), 32'h00000ABC);
    chk("slot oe", 32'(pin_oe), 32'h00000FFF);
    pins(16'h8000, 16'h0000);
    chk("slot off", 32'(pin_oe), 32'h00000000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    t_reset();
    t_static();
    t_edges();
    t_slot();
    report_and_stop();
  end
  initial
  begin
    #500000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> rtl/edge_cell.sv
// per-pin edge detector with masks and sticky hold bit
// assumes level is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module edge_cell
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin state and setup
  input wire logic level,
  input wire logic is_input,
  input wire logic fall_en,
  input wire logic rise_en,
  input wire logic hold_clr,
  // results
  output logic evt,
  output logic hold
);
  logic prev_r;
  logic prev_nxt;
  logic hold_r;
  logic hold_nxt;
  logic fell;
  logic rose;

  always_comb
  begin
    prev_nxt = level;
    fell = is_input && fall_en && prev_r && !level;
    rose = is_input && rise_en && !prev_r && level;
    hold_nxt = hold_r;
    if (hold_clr)
    begin
      hold_nxt = 1'b0;
    end
    if (fell || rose)
    begin
      hold_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prev_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign evt = fell || rose;
  assign hold = hold_r;
endmodule
`default_nettype wire

// >>> rtl/parallel_pin_port.sv
// parallel pin port on the multiplexed pins, with avalon-mm register slave
// assumes pins are outside the clk domain; pad logic resolves level from enables
// Summary of operation
// - in timeslot use the output value drives the low twelve pins while the top pin is high.
// - in static use the output value drives all sixteen pins set as outputs.
// - in timeslot use the low twelve pins are captured into the input value at the top pin's fall.
// - in static use the input value reads the present level of all sixteen pins.
// - each direction bit makes its pin an input at 0 and an output at 1, all 0 after reset.
// - an enabled falling edge on an input pin sets the pin event flag.
// - an enabled rising edge on an input pin sets the pin event flag.
// - the hold register collects every enabled edge on an input pin and keeps it.
// - a read of the hold register returns its bits and then clears it.
// - after a clear a hold bit sets again only on a new enabled edge.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module parallel_pin_port
#(
  parameter int PIN_W = pin_port_pkg::PIN_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // multiplexed pins
  input wire logic [PIN_W-1:0] pin_in,
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe,
  // interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [PIN_W-1:0] out_val_r, out_val_nxt;
  logic [PIN_W-1:0] way_r, way_nxt;
  logic [PIN_W-1:0] fall_r, fall_nxt;
  logic [PIN_W-1:0] rise_r, rise_nxt;
  logic [PIN_W-1:0] in_val_r, in_val_nxt;
  logic [1:0] use_r, use_nxt;
  logic evt_flag_r, evt_flag_nxt;
  logic evt_mask_r, evt_mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic [PIN_W-1:0] pout_r, pout_nxt;
  logic [PIN_W-1:0] poe_r, poe_nxt;
  logic irq_r, irq_nxt;
  logic slot_prev_r, slot_prev_nxt;
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] evt;
  logic [PIN_W-1:0] hold;
  logic [7:0] idx;
  logic wr_go;
  logic rd_go;
  logic hold_clr;
  logic slot_hi;
  logic slot_fall;
  logic any_evt;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++)
    begin : g_pin
      pin_sync u_sync
      (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(pin_in[g]),
        .level(lvl[g])
      );
      edge_cell u_edge
      (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(lvl[g]),
        .is_input(!way_r[g]),
        .fall_en(fall_r[g]),
        .rise_en(rise_r[g]),
        .hold_clr(hold_clr),
        .evt(evt[g]),
        .hold(hold[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // one wait cycle per access: request seen, answered on the next edge
  // writes land on the accepting edge; reads sample at the take so no hold event is lost
  assign idx = avs_address[9:2];
  assign wr_go = avs_write && ack_r;
  assign rd_go = avs_read && !ack_r;
  assign hold_clr = rd_go && (idx == pin_port_pkg::IDX_HOLD);
  assign any_evt = |evt;
  assign slot_hi = lvl[pin_port_pkg::SLOT_PIN];
  assign slot_fall = slot_prev_r && !slot_hi;

  always_comb
  begin
    out_val_nxt = out_val_r;
    way_nxt = way_r;
    fall_nxt = fall_r;
    rise_nxt = rise_r;
    use_nxt = use_r;
    evt_mask_nxt = evt_mask_r;
    evt_flag_nxt = evt_flag_r;
    rdata_nxt = rdata_r;
    ack_nxt = (avs_read || avs_write) && !ack_r;
    if (wr_go)
    begin
      case (idx)
        pin_port_pkg::IDX_OUT: out_val_nxt = avs_writedata[PIN_W-1:0];
        pin_port_pkg::IDX_WAY: way_nxt = avs_writedata[PIN_W-1:0];
        pin_port_pkg::IDX_FALL: fall_nxt = avs_writedata[PIN_W-1:0];
        pin_port_pkg::IDX_RISE: rise_nxt = avs_writedata[PIN_W-1:0];
        pin_port_pkg::IDX_SETUP: use_nxt = avs_writedata[pin_port_pkg::USE_LSB +: 2];
        pin_port_pkg::IDX_IMASK: evt_mask_nxt = avs_writedata[pin_port_pkg::EVT_BIT];
        pin_port_pkg::IDX_STATUS:
        begin
          if (avs_writedata[pin_port_pkg::EVT_BIT])
          begin
            evt_flag_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // set wins over a simultaneous clear
    if (any_evt)
    begin
      evt_flag_nxt = 1'b1;
    end
    if (rd_go)
    begin
      rdata_nxt = pin_port_pkg::UNMAPPED_DATA;
      case (idx)
        pin_port_pkg::IDX_OUT: rdata_nxt[PIN_W-1:0] = out_val_r;
        pin_port_pkg::IDX_IN:
        begin
          if (use_r == pin_port_pkg::USE_STATIC)
          begin
            rdata_nxt[PIN_W-1:0] = lvl;
          end
          else
          begin
            rdata_nxt[PIN_W-1:0] = in_val_r;
          end
        end
        pin_port_pkg::IDX_WAY: rdata_nxt[PIN_W-1:0] = way_r;
        pin_port_pkg::IDX_FALL: rdata_nxt[PIN_W-1:0] = fall_r;
        pin_port_pkg::IDX_RISE: rdata_nxt[PIN_W-1:0] = rise_r;
        pin_port_pkg::IDX_HOLD: rdata_nxt[PIN_W-1:0] = hold;
        pin_port_pkg::IDX_SETUP: rdata_nxt[pin_port_pkg::USE_LSB +: 2] = use_r;
        pin_port_pkg::IDX_STATUS: rdata_nxt[pin_port_pkg::EVT_BIT] = evt_flag_r;
        pin_port_pkg::IDX_IMASK: rdata_nxt[pin_port_pkg::EVT_BIT] = evt_mask_r;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive and capture
  always_comb
  begin
    pout_nxt = '0;
    poe_nxt = '0;
    in_val_nxt = in_val_r;
    slot_prev_nxt = slot_hi;
    irq_nxt = evt_flag_nxt && evt_mask_nxt;
    case (use_r)
      pin_port_pkg::USE_STATIC:
      begin
        pout_nxt = out_val_nxt;
        poe_nxt = way_nxt;
      end
      pin_port_pkg::USE_SLOT:
      begin
        // drive follows the synchronised top pin, so it lags the pin by about five cycles
        if (slot_hi)
        begin
          pout_nxt[pin_port_pkg::SLOT_W-1:0] = out_val_nxt[pin_port_pkg::SLOT_W-1:0];
          poe_nxt[pin_port_pkg::SLOT_W-1:0] = way_nxt[pin_port_pkg::SLOT_W-1:0];
        end
        if (slot_fall)
        begin
          in_val_nxt = '0;
          in_val_nxt[pin_port_pkg::SLOT_W-1:0] = lvl[pin_port_pkg::SLOT_W-1:0];
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      out_val_r <= pin_port_pkg::RST_WORD;
      way_r <= pin_port_pkg::RST_WORD;
      fall_r <= pin_port_pkg::RST_WORD;
      rise_r <= pin_port_pkg::RST_WORD;
      in_val_r <= pin_port_pkg::RST_WORD;
      use_r <= 2'h0;
      evt_flag_r <= 1'b0;
      evt_mask_r <= 1'b0;
      rdata_r <= 32'h00000000;
      ack_r <= 1'b0;
      pout_r <= '0;
      poe_r <= '0;
      irq_r <= 1'b0;
      slot_prev_r <= 1'b0;
    end
    else
    begin
      out_val_r <= out_val_nxt;
      way_r <= way_nxt;
      fall_r <= fall_nxt;
      rise_r <= rise_nxt;
      in_val_r <= in_val_nxt;
      use_r <= use_nxt;
      evt_flag_r <= evt_flag_nxt;
      evt_mask_r <= evt_mask_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
      irq_r <= irq_nxt;
      slot_prev_r <= slot_prev_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = !ack_r;
  assign pin_out = pout_r;
  assign pin_oe = poe_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  property p_static_drive;
    @(posedge clk) disable iff (sys_rst)
    (use_r == pin_port_pkg::USE_STATIC) && $stable(use_r) |-> (pin_out == out_val_r)
      && (pin_oe == way_r);
  endproperty
  a_static_drive: assert property (p_static_drive) else $error("static drive wrong");

  property p_slot_drive;
    @(posedge clk) disable iff (sys_rst)
    (use_r == pin_port_pkg::USE_SLOT) && slot_hi ##1 $stable(use_r) |->
      (pin_oe == {{(PIN_W-pin_port_pkg::SLOT_W){1'b0}}, way_r[pin_port_pkg::SLOT_W-1:0]})
      && (pin_out[pin_port_pkg::SLOT_W-1:0] == out_val_r[pin_port_pkg::SLOT_W-1:0]);
  endproperty
  a_slot_drive: assert property (p_slot_drive) else $error("slot enable wrong");

  property p_slot_quiet;
    @(posedge clk) disable iff (sys_rst)
    (use_r == pin_port_pkg::USE_SLOT) && !slot_hi ##1 $stable(use_r) |-> pin_oe == '0;
  endproperty
  a_slot_quiet: assert property (p_slot_quiet) else $error("slot drive outside window");

  property p_capture;
    @(posedge clk) disable iff (sys_rst)
    (use_r == pin_port_pkg::USE_SLOT) && slot_fall |=>
      in_val_r == {{(PIN_W-pin_port_pkg::SLOT_W){1'b0}}, $past(lvl[pin_port_pkg::SLOT_W-1:0])};
  endproperty
  a_capture: assert property (p_capture) else $error("slot capture wrong");

  property p_flag_set;
    @(posedge clk) disable iff (sys_rst)
    any_evt |=> evt_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag not set");

  property p_hold_clear;
    @(posedge clk) disable iff (sys_rst)
    hold_clr && !any_evt |=> hold == '0;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("hold not cleared");

  property p_hold_sticky;
    @(posedge clk) disable iff (sys_rst)
    !hold_clr |=> (hold & $past(hold)) == $past(hold);
  endproperty
  a_hold_sticky: assert property (p_hold_sticky) else $error("hold bit lost");

  property p_hold_cause;
    @(posedge clk) disable iff (sys_rst)
    (hold & ~$past(hold)) != '0 |-> $past(any_evt);
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("hold set without edge");

  property p_input_only;
    @(posedge clk) disable iff (sys_rst)
    (evt & way_r) == '0;
  endproperty
  a_input_only: assert property (p_input_only) else $error("edge on output pin");

  property p_wait;
    @(posedge clk) disable iff (sys_rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("no bus answer");

  property p_static_read;
    @(posedge clk) disable iff (sys_rst)
    rd_go && (idx == pin_port_pkg::IDX_IN) && (use_r == pin_port_pkg::USE_STATIC) |=>
      avs_readdata == {{($bits(avs_readdata)-PIN_W){1'b0}}, $past(lvl)};
  endproperty
  a_static_read: assert property (p_static_read) else $error("static input read wrong");
endmodule
`default_nettype wire

// >>> rtl/pin_port_pkg.sv
// constants shared by the parallel pin port design
// assumes a 40 MHz single clock domain and avalon-mm register access
package pin_port_pkg;
  localparam int PIN_W = 16;
  localparam int SLOT_W = 12;
  localparam int SLOT_PIN = 15;
  // register offsets are word indices; byte address is four times the index
  localparam logic [7:0] IDX_OUT = 8'h4D;
  localparam logic [7:0] IDX_IN = 8'h4E;
  localparam logic [7:0] IDX_WAY = 8'h4F;
  localparam logic [7:0] IDX_FALL = 8'h50;
  localparam logic [7:0] IDX_RISE = 8'h51;
  localparam logic [7:0] IDX_HOLD = 8'h52;
  localparam logic [7:0] IDX_SETUP = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h53;
  localparam logic [7:0] IDX_IMASK = 8'h54;
  localparam logic [1:0] USE_STATIC = 2'h1;
  localparam logic [1:0] USE_SLOT = 2'h2;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int EVT_BIT = 0;
  localparam int USE_LSB = 0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
  localparam int SYNC_STAGES = 3;
endpackage

// >>> rtl/pin_sync.sv
// three-stage synchroniser for one pin; output changes when stages two and three agree
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin in, filtered level out
  input wire logic pin_in,
  output logic level
);
  logic [pin_port_pkg::SYNC_STAGES-1:0] stage_r;
  logic [pin_port_pkg::SYNC_STAGES-1:0] stage_nxt;
  logic level_r;
  logic level_nxt;

  always_comb
  begin
    stage_nxt = {stage_r[pin_port_pkg::SYNC_STAGES-2:0], pin_in};
    level_nxt = level_r;
    if (stage_r[1] == stage_r[2])
    begin
      level_nxt = stage_r[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage_r <= '0;
      level_r <= 1'b0;
    end
    else
    begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule
`default_nettype wire
